// [led_dim_pkg.sv]
/*
 * Shared constants and types of the LED dimming control core, plus the
 * colour-channel pulse-width modulator that the top module instantiates.
 * Assumes a single free-running reference clock standing in for the
 * charge-pump oscillator, and an active-low asynchronous reset.
 */

// ****************************************************************
// package
// ****************************************************************
package led_dim_pkg;
	localparam logic [6:0] BUS_ADDR = 7'h1b;
	localparam int PWM_SLOT_CYCLES = 16;
	localparam int PWM_SLOTS = 15;
	localparam int PWM_PERIOD = PWM_SLOT_CYCLES * PWM_SLOTS;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] LAST_DATA_BYTE = 2'h2;
	localparam int NUM_COLOURS = 3;
	// plain register port map
	localparam logic [1:0] REG_CMD = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [23:0] CMD_RESET = 24'h000000;
	// status field positions
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_GATE_BIT = 4;
	localparam int STAT_HOLD_BIT = 5;

	// command latch layout, first data byte in the top bits
	typedef struct packed {
		logic [3:0] red;
		logic [3:0] green;
		logic [3:0] blue;
		logic spare_bit;
		logic spare_two_to_sub;
		logic spare_one_to_sub;
		logic gate_to_sub;
		logic [3:0] main_code;
		logic [3:0] sub_code;
	} cmd_s;

	// one white current-source group: enable plus brightness code
	typedef struct packed {
		logic en;
		logic [3:0] code;
	} white_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_DATA = 3'b011,
		ST_DACK = 3'b100,
		ST_SKIP = 3'b101
	} i2c_state_e;
endpackage : led_dim_pkg

// ****************************************************************
// colour pwm
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none

module colour_pwm (
	input wire logic i_ref_clk, // oscillator clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic [11:0] i_codes, // red, green, blue duty codes
	input wire logic i_en, // colour display lit
	output logic [2:0] o_pwm // red, green, blue outputs
);
	logic [3:0] cyc_r;
	logic [3:0] cyc_nxt;
	logic [3:0] slot_r;
	logic [3:0] slot_nxt;
	logic [2:0] pwm_nxt;

	always_comb
	begin
		cyc_nxt = cyc_r + 4'h1;
		slot_nxt = slot_r;
		if (cyc_r == 4'(led_dim_pkg::PWM_SLOT_CYCLES - 1))
		begin
			slot_nxt = (slot_r == 4'(led_dim_pkg::PWM_SLOTS - 1)) ? 4'h0 : slot_r + 4'h1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < led_dim_pkg::NUM_COLOURS; g++)
		begin : g_ch
			// code 15 covers all fifteen slots, code 0 none
			always_comb
			begin
				pwm_nxt[g] = i_en && (slot_r < i_codes[g*4 +: 4]);
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cyc_r <= 4'h0;
			slot_r <= 4'h0;
			o_pwm <= 3'h0;
		end
		else
		begin
			cyc_r <= cyc_nxt;
			slot_r <= slot_nxt;
			o_pwm <= pwm_nxt;
		end
	end
endmodule : colour_pwm

`default_nettype wire

// [led_dimming_control.sv]
/*
 * Top of the LED dimming control core: write-only two-wire serial slave,
 * holding and command latches, display gating, white-source codes and the
 * colour pwm. A small plain register port gives direct access too.
 * Assumes serial pins and the gate pin are asynchronous to i_ref_clk and
 * that the serial clock is far slower than i_ref_clk.
 */
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module led_dimming_control (
	input wire logic i_ref_clk, // oscillator clock, 25 mhz
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_scl, // serial clock pin
	input wire logic i_sda_i, // serial data pin level
	output logic o_sda_o, // serial data drive value
	output logic o_sda_oe, // serial data drive enable, high pulls low
	input wire logic i_display_gate_pin, // display gate pin
	input wire logic [1:0] i_addr, // register index
	input wire logic [31:0] i_wdata, // register write data
	input wire logic i_wr, // register write strobe
	input wire logic i_rd, // register read strobe
	output logic [31:0] o_rdata, // read data, cycle after i_rd
	output logic o_red, // red pwm enable
	output logic o_green, // green pwm enable
	output logic o_blue, // blue pwm enable
	output led_dim_pkg::white_s o_main, // main display source
	output led_dim_pkg::white_s o_sub, // sub display source
	output led_dim_pkg::white_s o_spare_output_one, // first spare source
	output led_dim_pkg::white_s o_spare_output_two // second spare source
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// bit 0 scl, bit 1 sda, bit 2 gate pin
	logic [2:0] pins;
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic [2:0] s3_r;
	logic [2:0] filt_r;
	logic [2:0] filt_nxt;
	logic [2:0] prev_r;

	assign pins = {i_display_gate_pin, i_sda_i, i_scl};

	genvar p;
	generate
		for (p = 0; p < 3; p++)
		begin : g_pin
			// a change only counts once the second and third stages agree
			always_comb
			begin
				filt_nxt[p] = (s2_r[p] == s3_r[p]) ? s3_r[p] : filt_r[p];
			end
		end
	endgenerate

	// idle bus is high, so reset the serial stages high to avoid false edges
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_r <= 3'h3;
			s2_r <= 3'h3;
			s3_r <= 3'h3;
			filt_r <= 3'h3;
			prev_r <= 3'h3;
		end
		else
		begin
			s1_r <= pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= filt_nxt;
			prev_r <= filt_r;
		end
	end

	// ****************************************************************
	// bus condition decode
	// ****************************************************************
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic gate_lvl;

	assign scl_rise = filt_r[0] && !prev_r[0];
	assign scl_fall = !filt_r[0] && prev_r[0];
	assign bus_start = filt_r[0] && prev_r[0] && prev_r[1] && !filt_r[1];
	assign bus_stop = filt_r[0] && prev_r[0] && !prev_r[1] && filt_r[1];
	assign gate_lvl = filt_r[2];

	// ****************************************************************
	// serial slave
	// ****************************************************************
	led_dim_pkg::i2c_state_e state_r;
	led_dim_pkg::i2c_state_e state_nxt;
	logic [3:0] bits_r;
	logic [3:0] bits_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [1:0] idx_r;
	logic [1:0] idx_nxt;
	logic [15:0] stage_r;
	logic [15:0] stage_nxt;
	logic [23:0] hold_r;
	logic [23:0] hold_nxt;
	logic complete_r;
	logic complete_nxt;
	logic oe_r;
	logic oe_nxt;
	logic load_cmd;

	always_comb
	begin
		state_nxt = state_r;
		bits_nxt = bits_r;
		shift_nxt = shift_r;
		idx_nxt = idx_r;
		stage_nxt = stage_r;
		hold_nxt = hold_r;
		complete_nxt = complete_r;
		oe_nxt = oe_r;
		load_cmd = 1'b0;
		if (bus_start)
		begin
			// start and repeated start both restart address reception
			state_nxt = led_dim_pkg::ST_ADDR;
			bits_nxt = 4'h0;
			oe_nxt = 1'b0;
		end
		else if (bus_stop)
		begin
			// a stop with no finished set behind it changes nothing
			load_cmd = complete_r;
			complete_nxt = 1'b0;
			state_nxt = led_dim_pkg::ST_IDLE;
			oe_nxt = 1'b0;
		end
		else
		begin
			case (state_r)
				led_dim_pkg::ST_ADDR, led_dim_pkg::ST_DATA:
				begin
					if (scl_rise)
					begin
						shift_nxt = {shift_r[6:0], filt_r[1]};
						bits_nxt = bits_r + 4'h1;
					end
					else if (scl_fall && bits_r == led_dim_pkg::BYTE_BITS)
					begin
						if (state_r == led_dim_pkg::ST_ADDR)
						begin
							if (shift_r == {led_dim_pkg::BUS_ADDR, 1'b0})
							begin
								oe_nxt = 1'b1;
								idx_nxt = 2'h0;
								// once addressed, a stop before the third byte is ignored
								complete_nxt = 1'b0;
								state_nxt = led_dim_pkg::ST_AACK;
							end
							else
							begin
								state_nxt = led_dim_pkg::ST_SKIP;
							end
						end
						else
						begin
							oe_nxt = 1'b1;
							state_nxt = led_dim_pkg::ST_DACK;
							if (idx_r == led_dim_pkg::LAST_DATA_BYTE)
							begin
								hold_nxt = {stage_r, shift_r};
								complete_nxt = 1'b1;
							end
							else
							begin
								stage_nxt = {stage_r[7:0], shift_r};
							end
						end
					end
				end
				led_dim_pkg::ST_AACK:
				begin
					if (scl_fall)
					begin
						oe_nxt = 1'b0;
						bits_nxt = 4'h0;
						state_nxt = led_dim_pkg::ST_DATA;
					end
				end
				led_dim_pkg::ST_DACK:
				begin
					if (scl_fall)
					begin
						oe_nxt = 1'b0;
						bits_nxt = 4'h0;
						if (idx_r == led_dim_pkg::LAST_DATA_BYTE)
						begin
							// extra bytes beyond the third are left unacknowledged
							state_nxt = led_dim_pkg::ST_SKIP;
						end
						else
						begin
							idx_nxt = idx_r + 2'h1;
							state_nxt = led_dim_pkg::ST_DATA;
						end
					end
				end
				led_dim_pkg::ST_IDLE, led_dim_pkg::ST_SKIP:
				begin
					oe_nxt = 1'b0;
				end
				default:
				begin
					oe_nxt = 1'b0;
					state_nxt = led_dim_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= led_dim_pkg::ST_IDLE;
			bits_r <= 4'h0;
			shift_r <= 8'h00;
			idx_r <= 2'h0;
			stage_r <= 16'h0000;
			hold_r <= led_dim_pkg::CMD_RESET;
			complete_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			bits_r <= bits_nxt;
			shift_r <= shift_nxt;
			idx_r <= idx_nxt;
			stage_r <= stage_nxt;
			hold_r <= hold_nxt;
			complete_r <= complete_nxt;
			oe_r <= oe_nxt;
		end
	end

	// ****************************************************************
	// command latch and register port
	// ****************************************************************
	led_dim_pkg::cmd_s cmd_r;
	led_dim_pkg::cmd_s cmd_nxt;
	logic [31:0] rdata_nxt;

	always_comb
	begin
		cmd_nxt = cmd_r;
		// a direct register write takes precedence over a stop in the same cycle
		if (i_wr && i_addr == led_dim_pkg::REG_CMD)
		begin
			cmd_nxt = led_dim_pkg::cmd_s'(i_wdata[23:0]);
		end
		else if (load_cmd)
		begin
			cmd_nxt = led_dim_pkg::cmd_s'(hold_r);
		end
		rdata_nxt = 32'h00000000;
		if (i_rd)
		begin
			case (i_addr)
				led_dim_pkg::REG_CMD:
				begin
					rdata_nxt = {8'h00, cmd_r};
				end
				led_dim_pkg::REG_STATUS:
				begin
					rdata_nxt[led_dim_pkg::STAT_STATE_LSB +: 3] = state_r;
					rdata_nxt[led_dim_pkg::STAT_GATE_BIT] = gate_lvl;
					rdata_nxt[led_dim_pkg::STAT_HOLD_BIT] = complete_r;
				end
				default:
				begin
					rdata_nxt = 32'h00000000;
				end
			endcase
		end
	end

	// ****************************************************************
	// display gating and white sources
	// ****************************************************************
	logic rgb_lit;
	logic sub_lit;
	led_dim_pkg::white_s main_nxt;
	led_dim_pkg::white_s sub_nxt;
	led_dim_pkg::white_s one_nxt;
	led_dim_pkg::white_s two_nxt;

	// the gate pin only acts on the display it is steered to
	assign rgb_lit = cmd_r.gate_to_sub || gate_lvl;
	assign sub_lit = !cmd_r.gate_to_sub || gate_lvl;

	always_comb
	begin
		// code zero is shutdown; level scaling itself is in the analogue sources
		main_nxt.code = cmd_r.main_code;
		main_nxt.en = cmd_r.main_code != 4'h0;
		sub_nxt.code = sub_lit ? cmd_r.sub_code : 4'h0;
		sub_nxt.en = sub_lit && cmd_r.sub_code != 4'h0;
		one_nxt = cmd_r.spare_one_to_sub ? sub_nxt : main_nxt;
		two_nxt = cmd_r.spare_two_to_sub ? sub_nxt : main_nxt;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cmd_r <= led_dim_pkg::cmd_s'(led_dim_pkg::CMD_RESET);
			o_rdata <= 32'h00000000;
			o_main <= '0;
			o_sub <= '0;
			o_spare_output_one <= '0;
			o_spare_output_two <= '0;
			o_sda_o <= 1'b0;
			o_sda_oe <= 1'b0;
		end
		else
		begin
			cmd_r <= cmd_nxt;
			o_rdata <= rdata_nxt;
			o_main <= main_nxt;
			o_sub <= sub_nxt;
			o_spare_output_one <= one_nxt;
			o_spare_output_two <= two_nxt;
			// open drain: drive value is always low, only the enable moves
			o_sda_o <= 1'b0;
			o_sda_oe <= oe_r;
		end
	end

	// ****************************************************************
	// colour channels
	// ****************************************************************
	logic [2:0] pwm;

	colour_pwm u_colour_pwm (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_codes({cmd_r.blue, cmd_r.green, cmd_r.red}),
		.i_en(rgb_lit),
		.o_pwm(pwm)
	);

	assign o_red = pwm[0];
	assign o_green = pwm[1];
	assign o_blue = pwm[2];
endmodule : led_dimming_control

`default_nettype wire

// [led_dim_checks_asserts.sv]
/*
 * port checks of the led dimming core.
 * assumes one reference clock and an active-low async reset.
 */
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module led_dim_checks (
	input wire logic i_ref_clk, // clock
	input wire logic i_rst_n, // reset, active low
	input wire logic i_scl, // serial clock pin
	input wire logic [1:0] i_addr, // register index
	input wire logic i_rd, // read strobe
	input wire logic [31:0] o_rdata, // read data
	input wire logic o_sda_oe, // ack drive
	input wire logic o_blue, // blue pwm
	input wire led_dim_pkg::white_s o_main, // main source
	input wire led_dim_pkg::white_s o_sub, // sub source
	input wire led_dim_pkg::white_s o_spare_output_one, // spare one
	input wire led_dim_pkg::white_s o_spare_output_two // spare two
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	a_main_en_code: assert property (o_main.en == (o_main.code != 4'h0))
		else $error("main enable disagrees with code");
	a_sub_en_code: assert property (o_sub.en == (o_sub.code != 4'h0))
		else $error("sub enable disagrees with code");
	a_spare_one_follow: assert property (o_spare_output_one == o_main || o_spare_output_one == o_sub)
		else $error("spare one matches no display");
	a_spare_two_follow: assert property (o_spare_output_two == o_main || o_spare_output_two == o_sub)
		else $error("spare two matches no display");
	a_reset_clears: assert property ($rose(i_rst_n) |-> o_main == 5'h0 && o_sub == 5'h0 && !o_blue)
		else $error("outputs not clear after reset");
	a_blue_period: assert property ($rose(o_blue) |-> ##240 o_blue)
		else $error("blue period is not 240 cycles");
	a_ack_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl ##1 o_sda_oe)
		else $error("ack raised while serial clock high");
	a_ack_release: assert property ($fell(o_sda_oe) |-> !i_scl)
		else $error("ack dropped while serial clock high");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 2'h1 |-> o_rdata == 32'h0)
		else $error("unmapped index read nonzero");
	c_ack_seen: cover property ($rose(o_sda_oe));
	c_blue_on: cover property ($rose(o_blue));
	c_sub_lit: cover property (o_sub.en);
endmodule : led_dim_checks

bind led_dimming_control led_dim_checks u_led_dim_checks (.i_ref_clk, .i_rst_n, .i_scl, .i_addr, .i_rd,
	.o_rdata, .o_sda_oe, .o_blue, .o_main, .o_sub, .o_spare_output_one, .o_spare_output_two);
`default_nettype wire

// [i2c_host_model.sv]
/*
 * write-only two-wire bus master standing in for the host processor.
 * assumes a pull-up resolves the data line outside this model.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	input wire logic i_ref_clk, // pacing clock
	input wire logic i_sda, // resolved data line
	output var logic o_scl, // serial clock
	output var logic o_sda // data drive, high releases
);
	// keeps clock high and low periods inside the bus timing limits
	localparam int HALF = 17;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic tick();
		repeat (HALF) @(posedge i_ref_clk);
	endtask : tick
	// data moves only while the clock is low, so no false start or stop
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			o_sda <= b[i];
			tick();
			o_scl <= 1'b1;
			tick();
			o_scl <= 1'b0;
			tick();
		end
		o_sda <= 1'b1;
		tick();
		o_scl <= 1'b1;
		tick();
		ack = !i_sda;
		o_scl <= 1'b0;
		tick();
	endtask : put_byte
	task automatic send(input logic [7:0] a, input logic [23:0] d, input int nb, output logic [3:0] acks);
		logic k;
		acks = 4'h0;
		o_sda <= 1'b0;
		tick();
		o_scl <= 1'b0;
		tick();
		put_byte(a, k);
		acks[3] = k;
		for (int j = 0; j < nb; j++)
		begin
			put_byte(d[23 - 8 * j -: 8], k);
			acks[2 - j] = k;
		end
		o_sda <= 1'b0;
		tick();
		o_scl <= 1'b1;
		tick();
		o_sda <= 1'b1;
		// two ticks of bus free time before any following start
		tick();
		tick();
	endtask : send
endmodule : i2c_host_model
`default_nettype wire

// [led_dimming_control_tb_top.sv]
/*
 * self-checking bench of the led dimming core.
 * assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`default_nettype none
module led_dimming_control_tb_top;
	logic i_ref_clk, i_rst_n, i_display_gate_pin, i_wr, i_rd, host_scl, host_sda, o_sda_o, o_sda_oe;
	logic o_red, o_green, o_blue;
	logic [1:0] i_addr;
	logic [31:0] i_wdata, o_rdata, rv;
	logic [3:0] acks;
	led_dim_pkg::white_s o_main, o_sub, o_spare_output_one, o_spare_output_two;
	int fails, n_tests;
	wire logic sda_line;
	// line is pulled up unless the host drives low or the device enables its drive value
	assign sda_line = host_sda & (o_sda_o | !o_sda_oe);
	led_dimming_control u_led_dimming_control (.i_ref_clk, .i_rst_n, .i_scl(host_scl), .i_sda_i(sda_line),
		.o_sda_o, .o_sda_oe, .i_display_gate_pin, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_red,
		.o_green, .o_blue, .o_main, .o_sub, .o_spare_output_one, .o_spare_output_two);
	i2c_host_model u_i2c_host_model (.i_ref_clk, .i_sda(sda_line), .o_scl(host_scl), .o_sda(host_sda));
	initial
	begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	// ****
	// tasks
	// ****
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			$display("unexpected at %0t got %h exp %h", $time, g, e);
			fails++;
		end
	endtask : chk
	task automatic wait_n(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : wait_n
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic t_serial();
		u_i2c_host_model.send(8'h36, 24'h00005a, 3, acks);
		chk(32'(acks), 32'hf);
		wait_n(10);
		rd(2'h0, rv);
		chk(rv, 32'h5a);
		chk(32'(o_main), 32'h15);
		chk(32'(o_sub), 32'h1a);
		$display("test serial done");
	endtask : t_serial
	task automatic t_refuse();
		u_i2c_host_model.send(8'h37, 24'h000011, 3, acks);
		chk(32'(acks), 32'h0);
		u_i2c_host_model.send(8'h36, 24'h000022, 1, acks);
		chk(32'(acks), 32'hc);
		wait_n(10);
		rd(2'h0, rv);
		chk(rv, 32'h5a);
		rd(2'h3, rv);
		chk(rv, 32'h0);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_gate();
		wr(2'h0, 32'hf00015);
		wait_n(8);
		chk(32'(o_red), 32'h0);
		chk(32'(o_sub), 32'h15);
		@(posedge i_ref_clk);
		i_display_gate_pin <= 1'b1;
		wait_n(8);
		chk(32'(o_red), 32'h1);
		rd(2'h1, rv);
		chk(rv, 32'h10);
		wr(2'h0, 32'hf00115);
		wait_n(8);
		chk(32'(o_sub), 32'h15);
		@(posedge i_ref_clk);
		i_display_gate_pin <= 1'b0;
		wait_n(8);
		chk(32'(o_sub), 32'h0);
		chk(32'(o_red), 32'h1);
		$display("test gate done");
	endtask : t_gate
	task automatic t_spare();
		for (int k = 0; k < 2; k++)
		begin
			wr(2'h0, k ? 32'h000237 : 32'h000437);
			wait_n(4);
			chk(32'(o_spare_output_one), k ? 32'h17 : 32'h13);
			chk(32'(o_spare_output_two), k ? 32'h13 : 32'h17);
		end
		$display("test spare done");
	endtask : t_spare
	task automatic t_pwm();
		logic [31:0] r, g, b;
		r = 0;
		g = 0;
		b = 0;
		wr(2'h0, 32'h1fe100);
		wait_n(4);
		repeat (240)
		begin
			wait_n(1);
			r += 32'(o_red);
			g += 32'(o_green);
			b += 32'(o_blue);
		end
		chk(32'(r), 32'h10);
		chk(32'(g), 32'hf0);
		chk(32'(b), 32'he0);
		chk(32'(o_main), 32'h0);
		$display("test pwm done");
	endtask : t_pwm
	task automatic t_reset();
		@(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		wait_n(4);
		rd(2'h0, rv);
		chk(rv, 32'h0);
		chk(32'({o_main, o_sub, o_spare_output_one, o_spare_output_two, o_blue}), 32'h0);
		$display("test reset done");
	endtask : t_reset
	// ****
	// main sequence
	// ****
	initial
	begin
		#3000000;
		fails++;
		give_verdict();
	end
	initial
	begin
		fails = 0;
		n_tests = 0;
		i_rst_n = 1'b0;
		i_display_gate_pin = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 2'h0;
		i_wdata = 32'h0;
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		wait_n(4);
		t_serial();
		t_refuse();
		t_gate();
		t_spare();
		t_pwm();
		t_reset();
		give_verdict();
	end
endmodule : led_dimming_control_tb_top
`default_nettype wire
